// ===== common/fdf_defines.svh
`ifndef FDF_DEFINES_SVH
`define FDF_DEFINES_SVH
// ****************************************
// Register offsets and reset values
// ****************************************
`define FDF_OFS_CMD 2'h0
`define FDF_OFS_TRK 2'h1
`define FDF_OFS_SEC 2'h2
`define FDF_OFS_DAT 2'h3
`define FDF_RST_CMD 8'h03
`define FDF_RST_SEC 8'h01
`define FDF_FORCE 4'hD
`define FDF_ZONE_TRK 8'h2C
`define FDF_CRC_POLY 16'h1021
`define FDF_CRC_INIT 16'hFFFF
`define FDF_SYNC_BITS 5'h10
// ****************************************
// Timing in its own unit
// ****************************************
`define FDF_CLK_NS 20
`define FDF_WP_DD_NS 250
`define FDF_WP_SD_NS 500
`define FDF_CELL_DD_NS 2000
`define FDF_CELL_SD_NS 4000
`define FDF_STEP_PW_NS 2000
`endif

// ===== common/fdf_pkg.sv
package fdf_pkg;
   typedef enum {S_IDLE, S_START, S_STEP, S_GAP, S_HEAD, S_SYNC, S_XFER, S_DONE} fdf_state_t;
   typedef enum {K_RESTORE, K_SEEK, K_STEP, K_READ, K_WRITE, K_OTHER} fdf_kind_t;
endpackage : fdf_pkg

// ===== hdl/fdf_core.sv
`include "fdf_defines.svh"
// Contract
// - Strobes with select latch or drive register
// - Select 00 status/command, 01 track, 10 sector, 11 data
// - Inverted eight-bit bus, direction by strobes
// - Transfer request marks full or empty data
// - Interrupt on completion, cleared by status/command access
// - One step pulse each, direction high inward
// - Early and late precompensation flags
// - Head engaged high means head loaded
// - Side output follows S flag at start
// - Sync gate high after zero field
// - Outer zone shows track 44 and above while a non-step command is busy
// - Write pulse per flux, density sets width
// - Read/write need ready, else interrupt
// - Shared pin: fault input while writing
// - Separator enable low while reading data
// - Write protect low aborts write, flags status
// - Density input 0 double, 1 single
// - Track follows steps, compared with ID
// - Sector compared with ID during reads
// - Command write-only, status read-only, force interrupt
// - CRC polynomial x16+x12+x5+1
// - Master reset loads 03, then restore
module fdf_core
#(
   parameter int SECT_BYTES = 128,
   parameter int STEP_US    = 3000
)
(
   input  wire logic       clk_sys_i,
   input  wire logic       reset_n_i,
   input  wire logic       master_reset_n_i,
   input  wire logic       cs_n_i,
   input  wire logic       write_strobe_n_i,
   input  wire logic       read_strobe_n_i,
   input  wire logic       reg_sel_lo_i,
   input  wire logic       reg_sel_hi_i,
   input  wire logic [7:0] host_bus_n_i,
   output logic      [7:0] host_bus_n_o,
   output logic            host_bus_oe_n_o,
   output logic            xfer_request_o,
   output logic            done_irq_o,
   output logic            step_o,
   output logic            step_dir_o,
   output logic            early_o,
   output logic            late_o,
   output logic            head_load_out_o,
   input  wire logic       head_engaged_in_i,
   output logic            read_sync_gate_o,
   output logic            side_out_o,
   output logic            outer_zone_out_o,
   output logic            write_pulse_out_o,
   output logic            write_gate_out_o,
   input  wire logic       ready_i,
   input  wire logic       write_fault_in_i,
   output logic            separator_enable_out_o,
   output logic            separator_enable_oe_n_o,
   input  wire logic       track0_i,
   input  wire logic       protect_in_i,
   input  wire logic       density_sel_i,
   input  wire logic       read_clk_i,
   input  wire logic       raw_read_n_i
);
   import fdf_pkg::*;

   localparam int CLK = `FDF_CLK_NS;
   localparam int WPD = (`FDF_WP_DD_NS + CLK - 1) / CLK;
   localparam int WPS = (`FDF_WP_SD_NS + CLK - 1) / CLK;
   localparam int CLD = `FDF_CELL_DD_NS / CLK;
   localparam int CLS = `FDF_CELL_SD_NS / CLK;
   localparam int SPW = (`FDF_STEP_PW_NS + CLK - 1) / CLK;
   localparam int STC = STEP_US * 1000 / CLK;
   localparam logic [19:0] STC20 = 20'(STC);
   localparam logic [19:0] SPT   = 20'(STC - SPW);
   localparam logic [9:0]  NSEC  = 10'(SECT_BYTES);

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);

   // ****************************************
   // Input synchronisers
   // ****************************************
   logic [21:0] s1;
   logic [21:0] s2;
   wire  [21:0] a_in = {host_bus_n_i, cs_n_i, write_strobe_n_i, read_strobe_n_i,
                        reg_sel_hi_i, reg_sel_lo_i, master_reset_n_i, head_engaged_in_i,
                        ready_i, write_fault_in_i, track0_i, protect_in_i,
                        density_sel_i, read_clk_i, raw_read_n_i};

   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i)
      begin
         s1 <= '1;
         s2 <= '1;
      end
      else
      begin
         s1 <= a_in;
         s2 <= s1;
      end
   end

   wire [7:0] bus_d = ~s2[21:14];
   wire [1:0] sel   = s2[10:9];
   wire       mr_n  = s2[8];
   wire       head_engaged_in   = s2[7];
   wire       rdy   = s2[6];
   wire       wf    = s2[5];
   wire       tr0   = s2[4];
   wire       wp    = s2[3];
   wire       density_sel  = s2[2];

   // ****************************************
   // State
   // ****************************************
   fdf_state_t  st;
   fdf_kind_t   kind;
   logic [7:0]  cmd, trk, sec, dat, sh, wdat;
   logic [1:0]  wsel;
   logic [19:0] tmr;
   logic [15:0] crc;
   logic [9:0]  bcnt;
   logic [4:0]  nrun, wpc;
   logic [2:0]  bitn;
   logic        wr_q, rd_q, rclk_q, mr_pend, t1, dir, stepped, prv;
   logic        f_wp, f_rnf, f_crc, f_lost, f_flt;

   // CRC preset to ones, one byte per call, msb first
   function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c;
      for (int i = 7; i >= 0; i--)
         r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? `FDF_CRC_POLY : 16'h0000);
      crc_upd = r;
   endfunction : crc_upd

   function automatic fdf_kind_t kind_of(input logic [7:0] c);
      if (c[7:4] == 4'h0)
         kind_of = K_RESTORE;
      else if (c[7:4] == 4'h1)
         kind_of = K_SEEK;
      else if (!c[7])
         kind_of = K_STEP;
      else if (c[7:5] == 3'h4)
         kind_of = K_READ;
      else if (c[7:5] == 3'h5)
         kind_of = K_WRITE;
      else
         kind_of = K_OTHER;
   endfunction : kind_of

   // ****************************************
   // Decode
   // ****************************************
   wire        wr_act  = !s2[13] && !s2[12];
   wire        rd_act  = !s2[13] && !s2[11];
   wire        wr_end  = wr_q && !wr_act;
   wire        rd_go   = rd_act && !rd_q;
   wire        busy    = st != S_IDLE;
   wire        force_c = wdat[7:4] == `FDF_FORCE;
   wire        go      = wr_end && wsel == `FDF_OFS_CMD && (!busy || force_c);
   wire        rbit_go = s2[1] && !rclk_q;
   wire        rbit    = !s2[0];
   wire        nrdy    = mr_n && !rdy;
   wire [19:0] cel     = density_sel ? 20'(CLS) : 20'(CLD);
   wire [4:0]  wpw     = density_sel ? 5'(WPS) : 5'(WPD);
   wire [7:0]  rb      = {sh[6:0], rbit};
   wire [7:0]  wr_src  = (bcnt < NSEC) ? (xfer_request_o ? 8'h00 : dat) :
                         (bcnt == NSEC) ? crc[15:8] : crc[7:0];
   wire [15:0] crc_n   = crc_upd(crc, (kind == K_READ) ? rb : wr_src);
   wire        cur     = (bitn == 3'h0) ? wr_src[7] : sh[6];
   wire        nxt     = (bitn == 3'h0) ? wr_src[6] : sh[5];
   wire        at_goal = (kind == K_RESTORE) ? tr0 : (kind == K_SEEK) ? (trk == dat) : stepped;
   wire        dir_new = (kind == K_RESTORE) ? 1'b0 : (kind == K_SEEK) ? (dat > trk) : dir;
   wire [7:0]  st1     = {nrdy, 1'b0, head_load_out_o && head_engaged_in, f_rnf, f_crc, tr0, 1'b0, busy};
   wire [7:0]  st2     = {nrdy, f_wp, f_flt, f_rnf, f_crc, f_lost, xfer_request_o, busy};
   wire [7:0]  rd_val  = (sel == `FDF_OFS_CMD) ? (t1 ? st1 : st2) :
                         (sel == `FDF_OFS_TRK) ? trk :
                         (sel == `FDF_OFS_SEC) ? sec : dat;
   wire        reading = kind == K_READ && (st == S_SYNC || st == S_XFER);

   // ****************************************
   // Host side and pin outputs
   // ****************************************
   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i)
      begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         // Idles high like the synchroniser, so no false bit edge follows reset
         rclk_q <= 1'b1;
         wsel <= 2'h0;
         wdat <= 8'h00;
         host_bus_n_o <= 8'hFF;
         host_bus_oe_n_o <= 1'b1;
         step_o <= 1'b0;
         write_pulse_out_o <= 1'b0;
         outer_zone_out_o <= 1'b0;
         separator_enable_out_o <= 1'b1;
         separator_enable_oe_n_o <= 1'b1;
      end
      else
      begin
         wr_q <= wr_act;
         rd_q <= rd_act;
         rclk_q <= s2[1];
         if (wr_act)
         begin
            wsel <= sel;
            wdat <= bus_d;
         end
         host_bus_n_o <= ~rd_val;
         host_bus_oe_n_o <= !rd_act;
         step_o <= st == S_GAP && tmr > SPT;
         write_pulse_out_o <= wpc != 5'h00;
         outer_zone_out_o <= !t1 && busy && trk >= `FDF_ZONE_TRK;
         // Pin is a fault input whenever the gate is up, so release it there
         separator_enable_oe_n_o <= write_gate_out_o;
         separator_enable_out_o <= !(reading && head_engaged_in);
      end
   end

   property p_bus_dir;
      1'b1 |=> host_bus_oe_n_o == !$past(rd_act);
   endproperty
   a_bus_dir: assert property (p_bus_dir) else $error("bus enable not from read strobe");
   property p_rd_mux;
      rd_act && sel == `FDF_OFS_SEC |=> host_bus_n_o == ~$past(sec);
   endproperty
   a_rd_mux: assert property (p_rd_mux) else $error("sector read not inverted value");
   property p_zone;
      outer_zone_out_o |-> $past(trk) >= `FDF_ZONE_TRK && !$past(t1);
   endproperty
   a_zone: assert property (p_zone) else $error("outer zone on low track");
   property p_wpulse;
      $rose(write_pulse_out_o) |-> write_pulse_out_o[*8];
   endproperty
   a_wpulse: assert property (p_wpulse) else $error("write pulse too short");
   property p_step;
      // Direction moves one cycle ahead of the pulse, so hold is checked from the next cycle
      $rose(step_o) |=> (step_o && $stable(step_dir_o))[*8];
   endproperty
   a_step: assert property (p_step) else $error("step pulse short or direction moved");

   // ****************************************
   // Command sequencer
   // ****************************************
   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i || !mr_n)
      begin
         st <= S_IDLE;
         kind <= K_RESTORE;
         cmd <= `FDF_RST_CMD;
         trk <= 8'h00;
         sec <= 8'h00;
         dat <= 8'h00;
         sh <= 8'h00;
         tmr <= 20'h00000;
         crc <= `FDF_CRC_INIT;
         bcnt <= 10'h000;
         nrun <= 5'h00;
         wpc <= 5'h00;
         bitn <= 3'h0;
         mr_pend <= 1'b1;
         {t1, dir, stepped, prv} <= 4'h8;
         {f_wp, f_rnf, f_crc, f_lost, f_flt} <= 5'h00;
         {xfer_request_o, done_irq_o, step_dir_o, early_o, late_o} <= 5'h00;
         {head_load_out_o, read_sync_gate_o, side_out_o, write_gate_out_o} <= 4'h0;
      end
      else
      begin
         if (wpc != 5'h00)
            wpc <= wpc - 5'h01;
         if ((rd_go && sel == `FDF_OFS_CMD) || go)
            done_irq_o <= 1'b0;
         if (wr_end && wsel == `FDF_OFS_TRK)
            trk <= wdat;
         if (wr_end && wsel == `FDF_OFS_SEC)
            sec <= wdat;
         if ((rd_go && sel == `FDF_OFS_DAT) || (wr_end && wsel == `FDF_OFS_DAT))
            xfer_request_o <= 1'b0;
         if (wr_end && wsel == `FDF_OFS_DAT)
            dat <= wdat;
         if (mr_pend)
         begin
            mr_pend <= 1'b0;
            sec <= `FDF_RST_SEC;
            kind <= K_RESTORE;
            st <= S_START;
         end
         else if (go)
         begin
            cmd <= wdat;
            kind <= kind_of(wdat);
            {f_wp, f_rnf, f_crc, f_lost, f_flt} <= 5'h00;
            st <= force_c ? S_DONE : S_START;
         end
         else
            unique case (st)
               S_IDLE: ;
               S_START:
                  if (kind == K_RESTORE || kind == K_SEEK || kind == K_STEP)
                  begin
                     t1 <= 1'b1;
                     stepped <= 1'b0;
                     head_load_out_o <= cmd[3];
                     dir <= (cmd[6:5] == 2'h1) ? dir : (cmd[6:5] == 2'h2);
                     st <= S_STEP;
                  end
                  else
                  begin
                     t1 <= 1'b0;
                     side_out_o <= cmd[1];
                     if (!rdy)
                        st <= S_DONE;
                     else if (kind == K_WRITE && !wp)
                     begin
                        f_wp <= 1'b1;
                        st <= S_DONE;
                     end
                     else
                     begin
                        head_load_out_o <= 1'b1;
                        st <= (kind == K_OTHER) ? S_DONE : S_HEAD;
                     end
                  end
               S_STEP:
                  if (at_goal)
                  begin
                     if (kind == K_RESTORE)
                        trk <= 8'h00;
                     st <= S_DONE;
                  end
                  else
                  begin
                     dir <= dir_new;
                     step_dir_o <= dir_new;
                     trk <= dir_new ? trk + 8'h01 : trk - 8'h01;
                     stepped <= 1'b1;
                     tmr <= STC20;
                     st <= S_GAP;
                  end
               S_GAP:
                  if (tmr == 20'h00000)
                     st <= S_STEP;
                  else
                     tmr <= tmr - 20'h00001;
               S_HEAD:
                  if (head_engaged_in)
                  begin
                     bcnt <= 10'h000;
                     bitn <= 3'h0;
                     nrun <= 5'h00;
                     crc <= `FDF_CRC_INIT;
                     prv <= 1'b0;
                     if (kind == K_WRITE)
                     begin
                        write_gate_out_o <= 1'b1;
                        xfer_request_o <= 1'b1;
                        tmr <= {cel[16:0], 3'h0};
                        st <= S_XFER;
                     end
                     else
                        st <= S_SYNC;
                  end
               S_SYNC:
                  if (rbit_go)
                  begin
                     if (!rbit)
                     begin
                        nrun <= (nrun == 5'h1F) ? nrun : nrun + 5'h01;
                        if (nrun >= `FDF_SYNC_BITS - 5'h01)
                           read_sync_gate_o <= 1'b1;
                     end
                     else if (read_sync_gate_o)
                        st <= S_XFER;
                     else
                        nrun <= 5'h00;
                  end
               S_XFER:
                  if (kind == K_READ)
                  begin
                     if (rbit_go)
                     begin
                        sh <= rb;
                        bitn <= bitn + 3'h1;
                        if (bitn == 3'h7)
                        begin
                           crc <= crc_n;
                           bcnt <= bcnt + 10'h001;
                           if ((bcnt == 10'h000 && rb != trk) ||
                               (bcnt == 10'h001 && rb != sec))
                           begin
                              f_rnf <= 1'b1;
                              st <= S_DONE;
                           end
                           else if (bcnt >= 10'h002 && bcnt < NSEC + 10'h002)
                           begin
                              f_lost <= f_lost || xfer_request_o;
                              dat <= rb;
                              xfer_request_o <= 1'b1;
                           end
                           else if (bcnt == NSEC + 10'h003)
                           begin
                              f_crc <= crc_n != 16'h0000;
                              st <= S_DONE;
                           end
                        end
                     end
                  end
                  else if (!wf)
                  begin
                     f_flt <= 1'b1;
                     st <= S_DONE;
                  end
                  else if (tmr != 20'h00000)
                     tmr <= tmr - 20'h00001;
                  else if (bitn == 3'h0 && bcnt == NSEC + 10'h002)
                     st <= S_DONE;
                  else
                  begin
                     // No clock bits or marks are encoded; each one bit is a flux pulse
                     tmr <= cel - 20'h00001;
                     bitn <= bitn + 3'h1;
                     prv <= cur;
                     if (cur)
                        wpc <= wpw;
                     early_o <= !density_sel && cur && !prv && nxt;
                     late_o <= !density_sel && cur && prv && !nxt;
                     if (bitn != 3'h0)
                        sh <= {sh[6:0], 1'b0};
                     else
                     begin
                        sh <= wr_src;
                        bcnt <= bcnt + 10'h001;
                        if (bcnt < NSEC)
                        begin
                           crc <= crc_n;
                           f_lost <= f_lost || xfer_request_o;
                           xfer_request_o <= bcnt < NSEC - 10'h001;
                        end
                     end
                  end
               S_DONE:
               begin
                  done_irq_o <= 1'b1;
                  xfer_request_o <= 1'b0;
                  {write_gate_out_o, read_sync_gate_o, early_o, late_o} <= 4'h0;
                  if (t1 && cmd[3:2] == 2'h0)
                     head_load_out_o <= 1'b0;
                  st <= S_IDLE;
               end
            endcase
      end
   end

   property p_trk_wr;
      wr_end && wsel == `FDF_OFS_TRK && st == S_IDLE && !mr_pend && mr_n
         |=> trk == $past(wdat);
   endproperty
   a_trk_wr: assert property (p_trk_wr) else $error("track write not latched");
   property p_drq_clr;
      ((rd_go && sel == `FDF_OFS_DAT) || (wr_end && wsel == `FDF_OFS_DAT))
         && kind == K_WRITE && st == S_XFER && tmr != 20'h00000 |=> !xfer_request_o;
   endproperty
   a_drq_clr: assert property (p_drq_clr) else $error("request not cleared on read");
   property p_irq;
      st == S_DONE && mr_n |=> done_irq_o;
   endproperty
   a_irq: assert property (p_irq) else $error("no interrupt at completion");
   property p_side;
      st != S_START && mr_n |=> $stable(side_out_o);
   endproperty
   a_side: assert property (p_side) else $error("side changed outside start");
   property p_nrdy;
      st == S_START && kind == K_READ && !rdy && mr_n && !go |=> st == S_DONE ##1 done_irq_o;
   endproperty
   a_nrdy: assert property (p_nrdy) else $error("read ran without ready");
   property p_fault;
      st == S_XFER && kind == K_WRITE && !wf && mr_n |=> st == S_DONE ##1 !write_gate_out_o;
   endproperty
   a_fault: assert property (p_fault) else $error("write fault did not stop write");
   property p_wprot;
      st == S_START && kind == K_WRITE && rdy && !wp && mr_n && !go |=> f_wp && st == S_DONE;
   endproperty
   a_wprot: assert property (p_wprot) else $error("protected write not stopped");
   property p_mreset;
      !mr_n |=> cmd == `FDF_RST_CMD && !side_out_o;
   endproperty
   a_mreset: assert property (p_mreset) else $error("master reset did not load command");

   c_read: cover property (st == S_XFER && kind == K_READ ##1 st == S_DONE && !f_rnf);
   c_write: cover property (st == S_XFER && kind == K_WRITE ##1 st == S_DONE && !f_flt);
   c_step: cover property ($rose(step_o) && step_dir_o);
   c_force: cover property (go && force_c && busy);

endmodule : fdf_core

// ===== sim/fdf_drive_model.sv
// ****************************************
// Drive mechanics: head position and load
// ****************************************
module fdf_drive_model
(
   input  wire logic clk_sys_i,
   input  wire logic step_i,
   input  wire logic dir_i,
   input  wire logic load_i,
   input  wire logic wpulse_i,
   output logic      track0_o,
   output logic      engaged_o,
   output int        steps_o,
   output int        pulses_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] pos    = 8'h00;
   logic       step_q = 1'b0;
   int         cnt    = 0;
   logic       wp_q   = 1'b0;
   int         npulse = 0;
   always @(posedge clk_sys_i)
   begin
      step_q <= step_i;
      // Edge counted, so a stretched pulse still moves one track
      if (step_i && !step_q)
      begin
         cnt <= cnt + 1;
         pos <= dir_i ? pos + 8'h01 : pos - 8'h01;
      end
      engaged_o <= load_i;
      wp_q <= wpulse_i;
      // One flux transition per rising edge of the write pulse
      if (wpulse_i && !wp_q)
         npulse <= npulse + 1;
   end
   assign track0_o = (pos == 8'h00);
   assign steps_o  = cnt;
   assign pulses_o = npulse;
endmodule : fdf_drive_model

// ===== sim/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic       clk_sys_i = 1'b0;
   logic       reset_n_i = 1'b0;
   logic       cs_n = 1'b1, we_n = 1'b1, re_n = 1'b1, ready = 1'b1, prot = 1'b1;
   logic       mreset_n = 1'b1, fault = 1'b1;
   logic [1:0] sel   = 2'h0;
   logic [7:0] bus_n = 8'hFF;
   logic [7:0] v;
   wire logic [7:0] dout_n;
   wire logic  oe_n, irq, step, dir, head_load_out, trk0, eng, side;
   wire logic  xfer_request, wg, zone, wpulse;
   int         steps, pulses, errors = 0, samples_checked = 0;
   always #10 clk_sys_i = ~clk_sys_i;
   fdf_core #(.SECT_BYTES(4), .STEP_US(3)) u_fdf_core
   (
      .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .master_reset_n_i(mreset_n),
      .cs_n_i(cs_n), .write_strobe_n_i(we_n), .read_strobe_n_i(re_n),
      .reg_sel_lo_i(sel[0]), .reg_sel_hi_i(sel[1]), .host_bus_n_i(bus_n),
      .host_bus_n_o(dout_n), .host_bus_oe_n_o(oe_n), .xfer_request_o(xfer_request),
      .done_irq_o(irq), .step_o(step), .step_dir_o(dir), .early_o(), .late_o(),
      .head_load_out_o(head_load_out), .head_engaged_in_i(eng), .read_sync_gate_o(),
      .side_out_o(side), .outer_zone_out_o(zone), .write_pulse_out_o(wpulse),
      .write_gate_out_o(wg),
      .ready_i(ready), .write_fault_in_i(fault), .separator_enable_out_o(),
      .separator_enable_oe_n_o(), .track0_i(trk0), .protect_in_i(prot),
      .density_sel_i(1'b0), .read_clk_i(1'b0), .raw_read_n_i(1'b1)
   );
   fdf_drive_model u_fdf_drive_model
   (
      .clk_sys_i(clk_sys_i), .step_i(step), .dir_i(dir), .load_i(head_load_out), .wpulse_i(wpulse),
      .track0_o(trk0), .engaged_o(eng), .steps_o(steps), .pulses_o(pulses)
   );
   // ****************************************
   // Host bus and checking helpers
   // ****************************************
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      cs_n  <= 1'b0;
      we_n  <= 1'b0;
      sel   <= a;
      bus_n <= ~d;
      repeat (4) @(posedge clk_sys_i);
      cs_n <= 1'b1;
      we_n <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
   endtask : wr
   // Strobe held four edges: the answer lands three edges after the pins fall
   task automatic rd(input logic [1:0] a, output logic [7:0] d);
      @(posedge clk_sys_i);
      cs_n <= 1'b0;
      re_n <= 1'b0;
      sel  <= a;
      repeat (4) @(posedge clk_sys_i);
      d = ~dout_n;
      chk("bus_oe_n", 8'h00, {7'h00, oe_n});
      cs_n <= 1'b1;
      re_n <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
   endtask : rd
   task automatic wait_irq(input int lim);
      int n;
      for (n = 0; n < lim && irq !== 1'b1; n++) @(posedge clk_sys_i);
      chk("done_irq", 8'h01, {7'h00, irq});
   endtask : wait_irq
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset();
      wait_irq(2000);
      rd(2'h2, v);
      chk("sector_reset", 8'h01, v);
      rd(2'h0, v);
      chk("status_restore", 8'h04, v & 8'h85);
      chk("irq_cleared", 8'h00, {7'h00, irq});
      $display("test reset done");
   endtask : t_reset
   task automatic t_regs();
      wr(2'h1, 8'h5A);
      wr(2'h2, 8'hA5);
      rd(2'h1, v);
      chk("track_reg", 8'h5A, v);
      rd(2'h2, v);
      chk("sector_reg", 8'hA5, v);
      $display("test regs done");
   endtask : t_regs
   task automatic t_step();
      int s0;
      s0 = steps;
      wr(2'h0, 8'h40);
      wait_irq(1000);
      chk("step_count_in", 8'h01, 8'(steps - s0));
      chk("dir_in", 8'h01, {7'h00, dir});
      rd(2'h1, v);
      chk("track_in", 8'h5B, v);
      wr(2'h0, 8'h60);
      chk("irq_cmd_clear", 8'h00, {7'h00, irq});
      wait_irq(1000);
      chk("step_count_out", 8'h02, 8'(steps - s0));
      chk("dir_out", 8'h00, {7'h00, dir});
      rd(2'h1, v);
      chk("track_out", 8'h5A, v);
      $display("test step done");
   endtask : t_step
   task automatic t_refuse();
      ready <= 1'b0;
      wr(2'h0, 8'h80);
      wait_irq(300);
      rd(2'h0, v);
      chk("status_nrdy", 8'h80, v & 8'h81);
      ready <= 1'b1;
      prot  <= 1'b0;
      wr(2'h0, 8'hA2);
      wait_irq(300);
      chk("side_out", 8'h01, {7'h00, side});
      rd(2'h0, v);
      chk("status_protect", 8'h40, v & 8'hC1);
      prot <= 1'b1;
      $display("test refuse done");
   endtask : t_refuse
   task automatic t_write();
      int n;
      wr(2'h0, 8'hA2);
      for (n = 0; n < 300 && xfer_request !== 1'b1; n++) @(posedge clk_sys_i);
      chk("drq_empty", 8'h01, {7'h00, xfer_request});
      chk("write_gate", 8'h01, {7'h00, wg});
      chk("outer_zone", 8'h01, {7'h00, zone});
      wr(2'h3, 8'hC0);
      chk("drq_loaded", 8'h00, {7'h00, xfer_request});
      for (n = 0; n < 2000 && xfer_request !== 1'b1; n++) @(posedge clk_sys_i);
      chk("drq_next", 8'h01, {7'h00, xfer_request});
      // Byte C0 gives two flux pulses; the next byte is not due for 800 cycles
      repeat (300) @(posedge clk_sys_i);
      chk("flux_pulses", 8'h02, 8'(pulses));
      fault <= 1'b0;
      wait_irq(300);
      chk("gate_off", 8'h00, {7'h00, wg});
      rd(2'h0, v);
      chk("status_fault", 8'h20, v & 8'h67);
      fault <= 1'b1;
      $display("test write done");
   endtask : t_write
   task automatic t_mreset();
      ready    <= 1'b0;
      mreset_n <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      chk("side_mr", 8'h00, {7'h00, side});
      rd(2'h0, v);
      chk("status_mr_nrdy", 8'h00, v & 8'h80);
      ready    <= 1'b1;
      mreset_n <= 1'b1;
      wait_irq(300);
      rd(2'h2, v);
      chk("sector_mr", 8'h01, v);
      rd(2'h1, v);
      chk("track_mr", 8'h00, v);
      $display("test mreset done");
   endtask : t_mreset
   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : close_out
   initial
   begin
      #400000;
      errors++;
      close_out();
   end
   initial
   begin
      repeat (20) @(posedge clk_sys_i);
      reset_n_i <= 1'b1;
      t_reset();
      t_regs();
      t_step();
      t_refuse();
      t_write();
      t_mreset();
      close_out();
   end
endmodule : tb_top
